// ===== inc/sar_ctrl_pkg.sv
// Shared constants and types for the converter sequencing block.
package sar_ctrl_pkg;

  // ***********************************************************************
  // Widths and control byte layout
  // ***********************************************************************
  localparam int RES_W      = 12;
  localparam int CTRL_W     = 8;
  localparam int CH_W       = 3;
  localparam int SYNC_W     = 3;

  // Power and clock select encodings.
  localparam logic [1:0] PWR_FULL_DOWN = 2'h0;
  localparam logic [1:0] PWR_STANDBY   = 2'h1;
  localparam logic [1:0] PWR_NORM_INT  = 2'h2;
  localparam logic [1:0] PWR_NORM_EXT  = 2'h3;

  typedef struct packed {
    logic [1:0]      power_clock_select;
    logic            sample_window_select;
    logic            input_pairing_select;
    logic            polarity_select;
    logic [CH_W-1:0] channel_index;
  } ctrl_byte_t;

  localparam ctrl_byte_t CTRL_RESET = '0;

  // ***********************************************************************
  // Sequencing counts and timing
  // ***********************************************************************
  localparam logic [3:0] ACQ_FALL_EDGES = 4'h4;
  localparam logic [3:0] CONV_TICKS     = 4'hd;
  localparam logic [3:0] TICK_ZERO      = 4'h0;
  localparam int CLK_PERIOD_PS    = 5000;
  localparam int CONV_TIME_INT_PS = 3600000;
  localparam int INT_TICK_CYCLES  =
    CONV_TIME_INT_PS / (13 * CLK_PERIOD_PS);
  localparam int DIV_W = 8;

  // Sequencer states, one-hot.
  typedef enum logic [3:0] {
    ST_IDLE    = 4'h1,
    ST_ACQ_INT = 4'h2,
    ST_ACQ_EXT = 4'h4,
    ST_CONV    = 4'h8
  } seq_state_t;

endpackage

// ===== rtl/sar_ctrl.sv
// Acquisition and conversion sequencer for a 12-bit SAR converter.
`timescale 1ns/1ps

// Behaviour
// - A chip-selected write of the control byte starts a conversion sequence.
// - Window select picks bare acquisition or acquisition plus conversion.
// - Tracking begins on the write strobe rising edge.
// - Host-bounded mode holds on the next write strobe rising edge with window select zero.
// - Internally timed mode holds on the fourth conversion clock falling edge.
// - Internal window lasts four conversion clock falling edges, then conversion starts itself.
// - Each conversion takes 13 conversion clock cycles.
// - A write during conversion aborts it and starts a new acquisition.
// - Window select one keeps acquisition open until the next write.
// - A second write with window select zero starts conversion.
// - Single-ended routes positive node to channel, negative to return.
// - Pseudo-differential connects both nodes to the selected channel pair.
// - Conversion start moves capacitor to negative node; twelve bits resolve.
// - Next acquisition reconnects the capacitor to the positive input.
// - Completion flag goes low when the result is ready.
// - Completion flag returns high on first read or a new write.
// - Bits seven, six give power and clock; bit five the window mode.
// - Bit four pairing, bit three polarity, bits two to zero channel.
// - External conversion clock is used after reset until changed.
// - Read strobe falling with chip select low drives the result out.
module sar_ctrl
  import sar_ctrl_pkg::*;
#(
  parameter int TICK_CYCLES = INT_TICK_CYCLES
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst,
  input  wire logic             i_cs_n,
  input  wire logic             i_wr_n,
  input  wire logic             i_rd_n,
  input  wire logic             i_conv_clk,
  input  wire logic [CTRL_W-1:0] i_data,
  input  wire logic             i_comp_high,
  output logic [RES_W-1:0]      o_data,
  output logic                  o_data_oe,
  output logic                  o_done_n,
  output logic                  o_done_oe,
  output logic                  o_track,
  output logic                  o_cap_neg,
  output logic [CH_W-1:0]       o_pos_channel,
  output logic [CH_W-1:0]       o_neg_channel,
  output logic                  o_neg_to_return,
  output logic                  o_unipolar,
  output logic [1:0]            o_power_mode,
  output logic                  o_clk_internal,
  output logic [RES_W-1:0]      o_dac_code
);

  // ***********************************************************************
  // State record
  // ***********************************************************************
  typedef struct packed {
    logic [SYNC_W-1:0] cs_s;
    logic [SYNC_W-1:0] wr_s;
    logic [SYNC_W-1:0] rd_s;
    logic [SYNC_W-1:0] clk_s;
    logic [1:0]        comp_s;
    logic [2*CTRL_W-1:0] data_s;
    seq_state_t        fsm;
    ctrl_byte_t        ctrl;
    logic              clk_internal;
    logic [DIV_W-1:0]  div_cnt;
    logic [3:0]        cnt;
    logic [RES_W-1:0]  trial;
    logic [RES_W-1:0]  result;
    logic              done_n;
    logic              done_oe;
    logic              data_oe;
    logic              track;
    logic              cap_neg;
    logic [CH_W-1:0]   pos_ch;
    logic [CH_W-1:0]   neg_ch;
    logic              neg_ret;
  } state_t;

  state_t r_reg;
  state_t r_next;

  // Trial bit mask for a given step of the approximation.
  function automatic logic [RES_W-1:0] bit_mask(input logic [3:0] idx);
    bit_mask = RES_W'(1) << idx;
  endfunction

  // Strobe edges, judged only on the second and third sync stages.
  logic       cs_low;
  logic       wr_rise;
  logic       rd_fall;
  logic       conv_tick;
  ctrl_byte_t wr_byte;
  logic [3:0] bit_idx;
  // Edge and tick detection on synchronised pins.
  always_comb begin
    cs_low    = !r_reg.cs_s[1];
    wr_rise   = cs_low && r_reg.wr_s[1] && !r_reg.wr_s[2];
    rd_fall   = cs_low && !r_reg.rd_s[1] && r_reg.rd_s[2];
    wr_byte   = ctrl_byte_t'(r_reg.data_s[2*CTRL_W-1:CTRL_W]);
    bit_idx   = 4'(RES_W) - r_reg.cnt;
    if (r_reg.clk_internal) begin
      conv_tick = (r_reg.div_cnt == DIV_W'(TICK_CYCLES - 1));
    end else begin
      conv_tick = !r_reg.clk_s[1] && r_reg.clk_s[2];
    end
  end

  // ***********************************************************************
  // Next-state logic
  // ***********************************************************************
  always_comb begin
    r_next = r_reg;
    // Three-stage synchronisers (two for the comparator and the data byte); stage zero feeds only stage one.
    r_next.cs_s   = {r_reg.cs_s[1:0], i_cs_n};
    r_next.wr_s   = {r_reg.wr_s[1:0], i_wr_n};
    r_next.rd_s   = {r_reg.rd_s[1:0], i_rd_n};
    r_next.clk_s  = {r_reg.clk_s[1:0], i_conv_clk};
    r_next.comp_s = {r_reg.comp_s[0], i_comp_high};
    r_next.data_s = {r_reg.data_s[CTRL_W-1:0], i_data};

    // Internal conversion clock divider.
    if (conv_tick && r_reg.clk_internal) begin
      r_next.div_cnt = '0;
    end else begin
      r_next.div_cnt = r_reg.div_cnt + DIV_W'(1);
    end

    // Bus drivers follow chip select and the read strobe.
    r_next.done_oe = cs_low;
    r_next.data_oe = cs_low && !r_reg.rd_s[1];

    // A read clears the completion flag.
    if (rd_fall) begin
      r_next.done_n = 1'b1;
    end

    unique case (r_reg.fsm)
      ST_ACQ_INT: begin
        if (conv_tick) begin
          r_next.cnt = r_reg.cnt + 4'h1;
          if (r_reg.cnt == ACQ_FALL_EDGES - 4'h1) begin
            // Fourth falling edge: hold and begin conversion.
            r_next.track   = 1'b0;
            r_next.cap_neg = 1'b1;
            r_next.cnt     = TICK_ZERO;
            r_next.fsm     = ST_CONV;
          end
        end
      end
      ST_ACQ_EXT: begin
        // Waits without limit for the next write below.
        r_next.fsm = ST_ACQ_EXT;
      end
      ST_CONV: begin
        if (conv_tick) begin
          r_next.cnt = r_reg.cnt + 4'h1;
          if (r_reg.cnt == TICK_ZERO) begin
            r_next.trial = bit_mask(4'(RES_W - 1));
          end else begin
            // Drop the trial bit when the comparator says too high.
            if (!r_reg.comp_s[1]) begin
              r_next.trial = r_reg.trial & ~bit_mask(bit_idx);
            end
            if (bit_idx != 4'h0) begin
              r_next.trial = r_next.trial | bit_mask(bit_idx - 4'h1);
            end
          end
          if (r_reg.cnt == CONV_TICKS - 4'h1) begin
            r_next.result = r_next.trial;
            r_next.done_n = 1'b0;
            r_next.fsm    = ST_IDLE;
          end
        end
      end
      ST_IDLE: begin
        r_next.fsm = ST_IDLE;
      end
    endcase

    // A chip-selected write overrides any sequence in progress.
    if (wr_rise) begin
      r_next.done_n = 1'b1;
      r_next.cnt    = TICK_ZERO;
      r_next.trial  = '0;
      r_next.result = r_reg.result;
      if (r_reg.fsm == ST_ACQ_EXT && !wr_byte.sample_window_select) begin
        // Second write ends the open window and converts.
        r_next.track   = 1'b0;
        r_next.cap_neg = 1'b1;
        r_next.fsm     = ST_CONV;
      end else begin
        r_next.track   = 1'b1;
        r_next.cap_neg = 1'b0;
        if (wr_byte.sample_window_select) begin
          r_next.fsm = ST_ACQ_EXT;
        end else begin
          r_next.fsm = ST_ACQ_INT;
        end
      end
      r_next.ctrl = wr_byte;
      // Power-down codes leave the clock source as it was.
      if (wr_byte.power_clock_select == PWR_NORM_INT) begin
        r_next.clk_internal = 1'b1;
        r_next.div_cnt      = '0;
      end else if (wr_byte.power_clock_select == PWR_NORM_EXT) begin
        r_next.clk_internal = 1'b0;
      end
    end

    // Input routing follows the latched control byte.
    r_next.pos_ch  = r_next.ctrl.channel_index;
    r_next.neg_ret = r_next.ctrl.input_pairing_select;
    if (r_next.ctrl.input_pairing_select) begin
      r_next.neg_ch = r_next.ctrl.channel_index;
    end else begin
      r_next.neg_ch = r_next.ctrl.channel_index ^ CH_W'(1);
    end
  end

  // ***********************************************************************
  // State register
  // ***********************************************************************
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      r_reg              <= '0;
      r_reg.cs_s         <= '1;
      r_reg.wr_s         <= '1;
      r_reg.rd_s         <= '1;
      r_reg.fsm          <= ST_IDLE;
      r_reg.ctrl         <= CTRL_RESET;
      r_reg.clk_internal <= 1'b0;
      r_reg.done_n       <= 1'b1;
      r_reg.neg_ch       <= CH_W'(1);
    end else begin
      r_reg <= r_next;
    end
  end

  // Outputs straight from the state register.
  assign o_data          = r_reg.result;
  assign o_data_oe       = r_reg.data_oe;
  assign o_done_n        = r_reg.done_n;
  assign o_done_oe       = r_reg.done_oe;
  assign o_track         = r_reg.track;
  assign o_cap_neg       = r_reg.cap_neg;
  assign o_pos_channel   = r_reg.pos_ch;
  assign o_neg_channel   = r_reg.neg_ch;
  assign o_neg_to_return = r_reg.neg_ret;
  assign o_unipolar      = r_reg.ctrl.polarity_select;
  assign o_power_mode    = r_reg.ctrl.power_clock_select;
  assign o_clk_internal  = r_reg.clk_internal;
  assign o_dac_code      = r_reg.trial;

  // ***********************************************************************
  // Checks
  // ***********************************************************************
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  // Ticks seen during the present conversion.
  logic [3:0] conv_ticks_seen;
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || r_reg.fsm != ST_CONV) begin
      conv_ticks_seen <= '0;
    end else if (conv_tick) begin
      conv_ticks_seen <= conv_ticks_seen + 4'h1;
    end
  end
  property p_track_on_write;
    wr_rise && !(r_reg.fsm == ST_ACQ_EXT && !wr_byte.sample_window_select)
      |=> o_track && o_done_n;
  endproperty
  a_track_on_write: assert property (p_track_on_write)
    else $error("Write did not start tracking.");
  property p_int_hold;
    r_reg.fsm == ST_ACQ_INT && conv_tick && r_reg.cnt == 4'h3 && !wr_rise
      |=> r_reg.fsm == ST_CONV && !o_track && o_cap_neg;
  endproperty
  a_int_hold: assert property (p_int_hold)
    else $error("Internal window did not hold on fourth edge.");
  property p_ext_end;
    r_reg.fsm == ST_ACQ_EXT && wr_rise && !wr_byte.sample_window_select
      |=> r_reg.fsm == ST_CONV && !o_track;
  endproperty
  a_ext_end: assert property (p_ext_end)
    else $error("Second write did not start conversion.");
  property p_ext_open;
    r_reg.fsm == ST_ACQ_EXT && !wr_rise |=> r_reg.fsm == ST_ACQ_EXT;
  endproperty
  a_ext_open: assert property (p_ext_open)
    else $error("Open window closed without a write.");
  property p_conv_len;
    $fell(o_done_n) |-> $past(conv_ticks_seen) == 4'hc;
  endproperty
  a_conv_len: assert property (p_conv_len)
    else $error("Conversion did not span thirteen clocks.");
  property p_abort;
    r_reg.fsm == ST_CONV && wr_rise |=> r_reg.fsm != ST_CONV && o_track;
  endproperty
  a_abort: assert property (p_abort)
    else $error("Write during conversion did not abort it.");
  property p_done_low;
    r_reg.fsm == ST_CONV && conv_tick && r_reg.cnt == 4'hc && !wr_rise
      |=> !o_done_n;
  endproperty
  a_done_low: assert property (p_done_low)
    else $error("Completion flag not raised.");
  property p_read_clears;
    rd_fall && !(r_reg.fsm == ST_CONV && conv_tick) |=> o_done_n && o_data_oe;
  endproperty
  a_read_clears: assert property (p_read_clears)
    else $error("Read did not clear flag or drive data.");
  property p_cs_ignore;
    r_reg.cs_s[1] |=> $stable(r_reg.ctrl) && !o_data_oe;
  endproperty
  a_cs_ignore: assert property (p_cs_ignore)
    else $error("Strobe acted while deselected.");
  property p_result_hold;
    !$fell(o_done_n) |-> $stable(o_data);
  endproperty
  a_result_hold: assert property (p_result_hold)
    else $error("Result changed without a completion.");
  property p_pairing;
    wr_rise |=> o_neg_to_return == $past(wr_byte.input_pairing_select) &&
      o_pos_channel == $past(wr_byte.channel_index);
  endproperty
  a_pairing: assert property (p_pairing)
    else $error("Input routing does not follow control byte.");

  c_int_conv: cover property (r_reg.fsm == ST_ACQ_INT ##[1:600] !o_done_n);
  c_ext_conv: cover property (r_reg.fsm == ST_ACQ_EXT ##[1:600] !o_done_n);
  c_abort: cover property (r_reg.fsm == ST_CONV && wr_rise);
  c_read: cover property (!o_done_n ##1 rd_fall);

endmodule

// ===== tb/sar_analog_model.sv
// Far-side model: external conversion clock and the analog comparator.
`timescale 1ns/1ps
module sar_analog_model
  import sar_ctrl_pkg::*;
#(
  parameter int HALF_NS = 70
) (
  input  wire logic [RES_W-1:0] i_dac_code,
  input  wire logic [RES_W-1:0] i_level,
  output logic                  o_conv_clk,
  output logic                  o_comp_high
);
  // ***********************************************************************
  // Conversion clock
  // ***********************************************************************
  // The conversion clock runs free, as a board oscillator on the pin would.
  initial begin
    o_conv_clk = 1'b0;
  end
  always begin
    #HALF_NS o_conv_clk = ~o_conv_clk;
  end

  // ***********************************************************************
  // Comparator
  // ***********************************************************************
  // The held sample is at or above the trial code, so the trial bit stays.
  assign o_comp_high = (i_level >= i_dac_code);
endmodule

// ===== tb/sar_ctrl_tb_top.sv
// Self-checking testbench for the converter sequencing block.
`timescale 1ns/1ps
module sar_ctrl_tb_top;
  import sar_ctrl_pkg::*;
  localparam int TICKS = 4;
  logic              i_sys_clk = 1'b0;
  logic              i_rst, i_cs_n, i_wr_n, i_rd_n, conv_clk, comp_high;
  logic [CTRL_W-1:0] i_data;
  logic [RES_W-1:0]  level, o_data, o_dac_code;
  logic              o_data_oe, o_done_n, o_done_oe, o_track, o_cap_neg;
  logic [CH_W-1:0]   o_pos_channel, o_neg_channel;
  logic              o_neg_to_return, o_unipolar, o_clk_internal, ci;
  logic [1:0]        o_power_mode;
  int                n_fail = 0, checked = 0, edges = 0, e0, e1, n;

  // ***********************************************************************
  // Clock, device and far side
  // ***********************************************************************
  // The system clock toggles every half period of 5 ns.
  always #2.5 i_sys_clk = ~i_sys_clk;
  // Falling edges of the conversion clock are counted as ticks.
  always @(negedge conv_clk) edges++;

  sar_ctrl #(.TICK_CYCLES(TICKS)) i_dut (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_cs_n(i_cs_n),
    .i_wr_n(i_wr_n), .i_rd_n(i_rd_n), .i_conv_clk(conv_clk),
    .i_data(i_data), .i_comp_high(comp_high), .o_data(o_data),
    .o_data_oe(o_data_oe), .o_done_n(o_done_n), .o_done_oe(o_done_oe),
    .o_track(o_track), .o_cap_neg(o_cap_neg),
    .o_pos_channel(o_pos_channel), .o_neg_channel(o_neg_channel),
    .o_neg_to_return(o_neg_to_return), .o_unipolar(o_unipolar),
    .o_power_mode(o_power_mode), .o_clk_internal(o_clk_internal),
    .o_dac_code(o_dac_code));

  sar_analog_model i_far (
    .i_dac_code(o_dac_code), .i_level(level),
    .o_conv_clk(conv_clk), .o_comp_high(comp_high));

  // ***********************************************************************
  // Tasks
  // ***********************************************************************
  // Inputs change 1 ns after each rising edge.
  task automatic step(input int k);
    repeat (k) @(posedge i_sys_clk);
    #1;
  endtask

  task automatic results();
    $display("checks %0d, failures %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_val(input logic [RES_W-1:0] got,
                         input logic [RES_W-1:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // Data is set up well before the strobe rises and held after it.
  task automatic wr(input logic [CTRL_W-1:0] d, input logic cs_n);
    i_cs_n = cs_n;
    i_data = d;
    step(4);
    i_wr_n = 1'b0;
    step(4);
    i_wr_n = 1'b1;
    // Ticks the device sees together with the write are not counted.
    step(1);
    e0 = edges;
    step(4);
    i_cs_n = 1'b1;
    step(5);
  endtask

  task automatic rd(input logic [RES_W-1:0] exp);
    i_cs_n = 1'b0;
    step(2);
    i_rd_n = 1'b0;
    step(6);
    chk_bit(o_data_oe, 1'b1);
    chk_val(o_data, exp);
    chk_bit(o_done_n, 1'b1);
    chk_bit(o_done_oe, 1'b1);
    i_rd_n = 1'b1;
    step(2);
    i_cs_n = 1'b1;
    step(6);
    chk_bit(o_data_oe, 1'b0);
    chk_bit(o_done_oe, 1'b0);
  endtask

  // Selects one flag of the device for a bounded wait.
  function automatic logic sel(input int k);
    return (k == 0) ? o_track : (k == 1) ? o_done_n : o_cap_neg;
  endfunction

  task automatic wait_sig(input int k, input logic v, output int c);
    c = 0;
    while (sel(k) !== v && c < 3000) begin
      step(1);
      c++;
    end
    if (sel(k) !== v) begin
      n_fail++;
      results();
    end
  endtask

  // ***********************************************************************
  // Main sequence
  // ***********************************************************************
  initial begin
    i_rst = 1'b1;
    i_cs_n = 1'b1;
    i_wr_n = 1'b1;
    i_rd_n = 1'b1;
    i_data = 8'h00;
    level = 12'ha5c;
    step(20);
    i_rst = 1'b0;
    step(2);
    chk_bit(o_done_n, 1'b1);
    chk_bit(o_clk_internal, 1'b0);
    wr(8'hdd, 1'b1);
    chk_bit(o_track, 1'b0);
    chk_val(RES_W'(o_power_mode), 12'h0);
    // Internal window on the external clock, single-ended, channel 5.
    wr(8'hdd, 1'b0);
    chk_bit(o_track, 1'b1);
    chk_val(RES_W'(o_pos_channel), 12'h5);
    chk_bit(o_neg_to_return, 1'b1);
    chk_bit(o_unipolar, 1'b1);
    wait_sig(0, 1'b0, n);
    chk_val(RES_W'(edges - e0), 12'h4);
    chk_bit(o_cap_neg, 1'b1);
    e1 = edges;
    wait_sig(1, 1'b0, n);
    chk_val(RES_W'(edges - e1), 12'hd);
    chk_val(o_data, level);
    chk_val(o_dac_code, 12'ha5c);
    rd(12'ha5c);
    // Host-bounded window, pseudo-differential, channel 2.
    level = 12'h3c1;
    wr(8'he2, 1'b0);
    chk_val(RES_W'(o_pos_channel), 12'h2);
    chk_val(RES_W'(o_neg_channel), 12'h3);
    chk_bit(o_unipolar, 1'b0);
    chk_val(o_dac_code, 12'h0);
    chk_bit(o_neg_to_return, 1'b0);
    chk_val(o_data, 12'ha5c);
    step(300);
    chk_bit(o_track, 1'b1);
    wr(8'hc2, 1'b0);
    chk_bit(o_track, 1'b0);
    chk_bit(o_cap_neg, 1'b1);
    wait_sig(1, 1'b0, n);
    chk_val(o_data, 12'h3c1);
    // A new write clears the flag; internal clock times the conversion.
    level = 12'h7ff;
    wr(8'h9d, 1'b0);
    chk_bit(o_done_n, 1'b1);
    chk_bit(o_clk_internal, 1'b1);
    wait_sig(2, 1'b1, n);
    wait_sig(1, 1'b0, n);
    chk_bit(n >= 13 * TICKS - 1 && n <= 13 * TICKS + 2, 1'b1);
    chk_val(o_data, 12'h7ff);
    // A write in mid-conversion aborts it and reopens the window.
    level = 12'h012;
    wr(8'h9d, 1'b0);
    wait_sig(2, 1'b1, n);
    step(10);
    wr(8'h9d, 1'b0);
    chk_bit(o_track, 1'b1);
    chk_bit(o_cap_neg, 1'b0);
    chk_bit(o_done_n, 1'b1);
    chk_val(o_data, 12'h7ff);
    wait_sig(1, 1'b0, n);
    chk_val(o_data, 12'h012);
    // Every power and clock code; power-down keeps the clock source.
    ci = 1'b1;
    for (int c = 0; c < 4; c++) begin
      wr({c[1:0], 6'h20}, 1'b0);
      ci = (c == 2) ? 1'b1 : (c == 3) ? 1'b0 : ci;
      chk_val(RES_W'(o_power_mode), RES_W'(c));
      chk_bit(o_clk_internal, ci);
    end
    results();
  end
endmodule
